// ### core/msm_pkg.sv
// member snapshot monitor: shared constants, register map and carrier types
// assumes a 40 MHz system clock and membership vectors delivered by the bus front end
//
// Operation
// - order starts a 30 second delay timer
// - active flag high exactly while timer runs
// - flag sent to all peers on order
// - all members mute both alarms during delay
// - save recognised members shortly before expiry
// - afterwards compare live set against saved set
// - saved member gone raises missing alarm
// - unsaved member seen raises extra alarm
// - id, interface or layer change clears saved
// - each alarm is its own logic flag
// - layer 1 monitors gensets and layer-1 breakers
// - layer 3 monitors group controllers and breakers
// - redundant ethernet tracks both buses, flags faults
// - report saved and live counts per class
package msm_pkg;

    // ****************************************************************
    // timing
    // ****************************************************************
    localparam int unsigned CLK_HZ          = 40_000_000;
    localparam int unsigned SNAP_DELAY_S    = 30;        // snapshot delay, seconds
    localparam int unsigned SNAP_LEAD_MS    = 100;       // capture lead before expiry, ms
    localparam int unsigned SNAP_CYCLES     = SNAP_DELAY_S * CLK_HZ;
    localparam int unsigned LEAD_CYCLES     = (SNAP_LEAD_MS * (CLK_HZ / 1000));
    localparam int          TIMER_W         = 31;

    // ****************************************************************
    // register map (byte addresses) and fields
    // ****************************************************************
    localparam logic [7:0]  ADDR_CTRL       = 8'h00;
    localparam logic [7:0]  ADDR_CFG        = 8'h04;
    localparam logic [7:0]  ADDR_STATUS     = 8'h08;
    localparam logic [7:0]  ADDR_COUNT      = 8'h0C;
    localparam logic [7:0]  ADDR_SAVED_CTL  = 8'h10;
    localparam logic [7:0]  ADDR_SAVED_BCU  = 8'h14;
    localparam int          CTRL_ORDER_BIT  = 0;
    localparam int          CFG_ID_LSB      = 0;
    localparam int          CFG_IF_LSB      = 8;
    localparam int          CFG_LAYER_BIT   = 16;
    localparam int          CNT_SAVED_CTL   = 0;
    localparam int          CNT_SAVED_BCU   = 8;
    localparam int          CNT_LIVE_CTL    = 16;
    localparam int          CNT_LIVE_BCU    = 24;
    localparam logic [31:0] RESET_WORD      = 32'h0000_0000;

    // ****************************************************************
    // load-share interface selections
    // ****************************************************************
    localparam logic [2:0]  IF_CAN1         = 3'h0;
    localparam logic [2:0]  IF_ETH_A        = 3'h1;
    localparam logic [2:0]  IF_CAN1_ETH_A   = 3'h2;
    localparam logic [2:0]  IF_ETH_B        = 3'h3;
    localparam logic [2:0]  IF_ETH_B_C      = 3'h4;

    localparam int          UNITS           = 32;
    localparam int          CNT_W           = 6;
    localparam int          SET_W           = 2 * UNITS;

    // members recognised on one bus, one bit per unit number
    typedef struct packed {
        logic [UNITS-1:0] genset;
        logic [UNITS-1:0] group_controller;
        logic [UNITS-1:0] breaker_control_unit_l1;
        logic [UNITS-1:0] breaker_control_unit_l3;
    } msm_members_s;

    // alarm flags for the equation system
    typedef struct packed {
        logic missing;
        logic extra;
        logic redundancy_lost;
        logic improper;
    } msm_alarms_s;

endpackage

// ### core/msm_popcount.sv
// member snapshot monitor: population count of a membership vector
// assumes a purely combinational use; output width must hold the vector width
`timescale 1ns/1ps

module msm_popcount #(
    parameter int W  = 32,
    parameter int CW = 6
) (
    input  wire logic [W-1:0]  bits_in,
    output logic      [CW-1:0] count_out
);

    // ripple sum; 32 inputs keep the adder chain short enough at 40 MHz
    always_comb begin
        count_out = '0;
        for (int i = 0; i < W; i++) begin
            count_out = count_out + CW'(bits_in[i]);
        end
    end

endmodule // msm_popcount

// ### core/msm_monitor.sv
// member snapshot monitor: delay timer, snapshot capture, alarms, avalon-mm slave
// assumes membership vectors and the peer flag are synchronous to sys_clk_in
`timescale 1ns/1ps

module msm_monitor #(
    parameter int unsigned SNAP_CYCLES_P = msm_pkg::SNAP_CYCLES,
    parameter int unsigned LEAD_CYCLES_P = msm_pkg::LEAD_CYCLES
) (
    input  wire logic                  sys_clk_in,
    input  wire logic                  arst_n_in,
    input  wire logic [7:0]            avs_address_in,
    input  wire logic                  avs_read_in,
    input  wire logic                  avs_write_in,
    input  wire logic [31:0]           avs_writedata_in,
    input  wire logic [3:0]            avs_byteenable_in,
    output logic      [31:0]           avs_readdata_out,
    output logic                       avs_waitrequest_out,
    input  wire msm_pkg::msm_members_s bus_a_in,
    input  wire msm_pkg::msm_members_s bus_b_in,
    input  wire logic                  peer_snap_in,
    output logic                       snap_flag_out,
    output logic                       snap_active_out,
    output logic                       missing_alarm_out,
    output logic                       extra_alarm_out,
    output logic                       redundancy_lost_out,
    output logic                       improper_member_out
);

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic                                 wait_q;
        logic [31:0]                          rdata;
        logic                                 order;
        logic                                 order_prev;
        logic                                 peer_prev;
        logic [7:0]                           dev_id;
        logic [2:0]                           iface;
        logic                                 layer3;
        logic [msm_pkg::TIMER_W-1:0]          timer;
        logic                                 active;
        logic                                 saved_valid;
        logic [msm_pkg::SET_W-1:0]            saved_a;
        logic [msm_pkg::SET_W-1:0]            saved_b;
        msm_pkg::msm_alarms_s                 alarms;
    } msm_state_s;

    msm_state_s st_reg;
    msm_state_s st_next;

    logic [msm_pkg::SET_W-1:0] live_a;
    logic [msm_pkg::SET_W-1:0] live_b;
    logic [msm_pkg::SET_W-1:0] seen;
    logic [msm_pkg::SET_W-1:0] saved_u;
    logic                      redundant;
    logic                      order_edge;
    logic                      mon_en;
    logic                      capture;
    logic                      cfg_changed;
    logic [31:0]               be_mask;
    logic [31:0]               rd_mux;
    logic [31:0]               cfg_word;
    logic [31:0]               cfg_new;
    logic [msm_pkg::CNT_W-1:0] cnt_saved_ctl;
    logic [msm_pkg::CNT_W-1:0] cnt_saved_bcu;
    logic [msm_pkg::CNT_W-1:0] cnt_live_ctl;
    logic [msm_pkg::CNT_W-1:0] cnt_live_bcu;

    // ****************************************************************
    // membership selection per layer and interface
    // ****************************************************************
    // layer 3 swaps the controller class and the breaker class together
    always_comb begin
        if (st_reg.layer3) begin
            live_a = {bus_a_in.group_controller, bus_a_in.breaker_control_unit_l3};
            live_b = {bus_b_in.group_controller, bus_b_in.breaker_control_unit_l3};
        end else begin
            live_a = {bus_a_in.genset, bus_a_in.breaker_control_unit_l1};
            live_b = {bus_b_in.genset, bus_b_in.breaker_control_unit_l1};
        end
    end

    // a member counts as present if either redundant bus still sees it
    assign redundant = (st_reg.iface == msm_pkg::IF_CAN1_ETH_A) ||
                       (st_reg.iface == msm_pkg::IF_ETH_B_C);
    assign seen      = redundant ? (live_a | live_b) : live_a;
    assign saved_u   = redundant ? (st_reg.saved_a | st_reg.saved_b) : st_reg.saved_a;

    // ****************************************************************
    // order detection, capture point, monitoring window
    // ****************************************************************
    // edges only: a source that never drops its order starts nothing new
    assign order_edge = (st_reg.order && !st_reg.order_prev) ||
                        (peer_snap_in && !st_reg.peer_prev);
    assign capture    = (st_reg.timer == msm_pkg::TIMER_W'(LEAD_CYCLES_P));
    // a peer still in its delay keeps this unit quiet as well
    assign mon_en     = st_reg.saved_valid && !st_reg.active && !peer_snap_in;

    // ****************************************************************
    // counts per device class
    // ****************************************************************
    // live counts use bus a; a redundant bus b only shows up in the alarms
    msm_popcount #(.W(msm_pkg::UNITS), .CW(msm_pkg::CNT_W)) u_cnt_saved_ctl (
        .bits_in   (st_reg.saved_a[msm_pkg::SET_W-1:msm_pkg::UNITS]),
        .count_out (cnt_saved_ctl)
    );
    msm_popcount #(.W(msm_pkg::UNITS), .CW(msm_pkg::CNT_W)) u_cnt_saved_bcu (
        .bits_in   (st_reg.saved_a[msm_pkg::UNITS-1:0]),
        .count_out (cnt_saved_bcu)
    );
    msm_popcount #(.W(msm_pkg::UNITS), .CW(msm_pkg::CNT_W)) u_cnt_live_ctl (
        .bits_in   (live_a[msm_pkg::SET_W-1:msm_pkg::UNITS]),
        .count_out (cnt_live_ctl)
    );
    msm_popcount #(.W(msm_pkg::UNITS), .CW(msm_pkg::CNT_W)) u_cnt_live_bcu (
        .bits_in   (live_a[msm_pkg::UNITS-1:0]),
        .count_out (cnt_live_bcu)
    );

    // ****************************************************************
    // register read mux and write merge
    // ****************************************************************
    always_comb begin
        be_mask  = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
                    {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
        cfg_word = msm_pkg::RESET_WORD;
        cfg_word[msm_pkg::CFG_ID_LSB +: 8]  = st_reg.dev_id;
        cfg_word[msm_pkg::CFG_IF_LSB +: 3]  = st_reg.iface;
        cfg_word[msm_pkg::CFG_LAYER_BIT]    = st_reg.layer3;
        cfg_new  = (cfg_word & ~be_mask) | (avs_writedata_in & be_mask);
        // only the defined fields matter; reserved bits never count as a change
        cfg_changed = (cfg_new[msm_pkg::CFG_ID_LSB +: 8] != st_reg.dev_id) ||
                      (cfg_new[msm_pkg::CFG_IF_LSB +: 3] != st_reg.iface) ||
                      (cfg_new[msm_pkg::CFG_LAYER_BIT] != st_reg.layer3);
        rd_mux   = msm_pkg::RESET_WORD;
        unique case (avs_address_in)
            msm_pkg::ADDR_CTRL: begin
                rd_mux[msm_pkg::CTRL_ORDER_BIT] = st_reg.order;
            end
            msm_pkg::ADDR_CFG: begin
                rd_mux = cfg_word;
            end
            msm_pkg::ADDR_STATUS: begin
                rd_mux[5:0] = {st_reg.alarms.improper, st_reg.alarms.redundancy_lost,
                               st_reg.alarms.extra, st_reg.alarms.missing,
                               st_reg.saved_valid, st_reg.active};
            end
            msm_pkg::ADDR_COUNT: begin
                rd_mux[msm_pkg::CNT_SAVED_CTL +: msm_pkg::CNT_W] = cnt_saved_ctl;
                rd_mux[msm_pkg::CNT_SAVED_BCU +: msm_pkg::CNT_W] = cnt_saved_bcu;
                rd_mux[msm_pkg::CNT_LIVE_CTL  +: msm_pkg::CNT_W] = cnt_live_ctl;
                rd_mux[msm_pkg::CNT_LIVE_BCU  +: msm_pkg::CNT_W] = cnt_live_bcu;
            end
            msm_pkg::ADDR_SAVED_CTL: begin
                rd_mux = st_reg.saved_a[msm_pkg::SET_W-1:msm_pkg::UNITS];
            end
            msm_pkg::ADDR_SAVED_BCU: begin
                rd_mux = st_reg.saved_a[msm_pkg::UNITS-1:0];
            end
            default: begin
                rd_mux = msm_pkg::RESET_WORD;   // unmapped reads return zero
            end
        endcase
    end

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb begin
        st_next            = st_reg;
        st_next.order_prev = st_reg.order;
        st_next.peer_prev  = peer_snap_in;

        // bus: one wait cycle, then a single-cycle answer with waitrequest low
        st_next.wait_q = 1'b1;
        if ((avs_read_in || avs_write_in) && st_reg.wait_q) begin
            st_next.wait_q = 1'b0;
            st_next.rdata  = avs_read_in ? rd_mux : msm_pkg::RESET_WORD;
        end
        // writes take effect at the edge where waitrequest is seen low
        if (avs_write_in && !st_reg.wait_q) begin
            if (avs_address_in == msm_pkg::ADDR_CTRL && avs_byteenable_in[0]) begin
                st_next.order = avs_writedata_in[msm_pkg::CTRL_ORDER_BIT];
            end
            if (avs_address_in == msm_pkg::ADDR_CFG) begin
                st_next.dev_id = cfg_new[msm_pkg::CFG_ID_LSB +: 8];
                st_next.iface  = cfg_new[msm_pkg::CFG_IF_LSB +: 3];
                st_next.layer3 = cfg_new[msm_pkg::CFG_LAYER_BIT];
                if (cfg_changed) begin
                    st_next.saved_valid = 1'b0;
                    st_next.saved_a     = '0;
                    st_next.saved_b     = '0;
                end
            end
        end

        // delay timer; an order during a running delay is ignored
        if (st_reg.timer != '0) begin
            st_next.timer = st_reg.timer - 1'b1;
        end else if (order_edge) begin
            st_next.timer = msm_pkg::TIMER_W'(SNAP_CYCLES_P);
        end
        st_next.active = (st_next.timer != '0);

        // capture after any clear so a snapshot in the same cycle survives
        if (capture) begin
            st_next.saved_a     = live_a;
            st_next.saved_b     = redundant ? live_b : '0;
            st_next.saved_valid = 1'b1;
        end

        // alarm flags follow the live comparison while monitoring
        st_next.alarms.missing  = mon_en && (|(saved_u & ~seen));
        st_next.alarms.extra    = mon_en && (|(seen & ~saved_u));
        st_next.alarms.redundancy_lost = mon_en && redundant &&
            (|((st_reg.saved_a & ~live_a & live_b) |
               (st_reg.saved_b & ~live_b & live_a)));
        st_next.alarms.improper = mon_en && redundant &&
            (|((live_a ^ live_b) & ~saved_u));
    end

    // ****************************************************************
    // state register
    // ****************************************************************
    // reset leaves waitrequest high so no request is answered while in reset
    always_ff @(posedge sys_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            st_reg        <= '0;
            st_reg.wait_q <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    // all outputs are plain state bits
    assign avs_readdata_out    = st_reg.rdata;
    assign avs_waitrequest_out = st_reg.wait_q;
    assign snap_flag_out       = st_reg.active;
    assign snap_active_out     = st_reg.active;
    assign missing_alarm_out   = st_reg.alarms.missing;
    assign extra_alarm_out     = st_reg.alarms.extra;
    assign redundancy_lost_out = st_reg.alarms.redundancy_lost;
    assign improper_member_out = st_reg.alarms.improper;

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!arst_n_in);

    // an order with the timer idle loads the full delay and raises both flags
    timer_start_a: assert property (
        (order_edge && st_reg.timer == '0)
        |=> (st_reg.timer == msm_pkg::TIMER_W'(SNAP_CYCLES_P)) && snap_active_out)
        else $error("delay timer did not load on order");

    // a second order inside the delay must not stretch it
    order_ignore_a: assert property (
        (order_edge && st_reg.timer > msm_pkg::TIMER_W'(1))
        |=> st_reg.timer == $past(st_reg.timer) - msm_pkg::TIMER_W'(1))
        else $error("running delay restarted by order");

    // the flags drop on the edge that empties the timer
    active_end_a: assert property (
        (st_reg.timer == msm_pkg::TIMER_W'(1))
        |=> !snap_active_out && (st_reg.timer == '0))
        else $error("active flag outlived the delay");

    active_match_a: assert property (
        (st_reg.timer > msm_pkg::TIMER_W'(1)) |=> snap_active_out && snap_flag_out)
        else $error("active or peer flag dropped while timer runs");

    // own delay or a peer's flag keeps both member alarms quiet
    mute_alarms_a: assert property (
        (snap_active_out || peer_snap_in)
        |=> !missing_alarm_out && !extra_alarm_out)
        else $error("alarm raised during snapshot delay");

    // with no saved reference there is nothing to compare against
    idle_mute_a: assert property (
        !st_reg.saved_valid |=> !missing_alarm_out && !extra_alarm_out)
        else $error("alarm raised with no saved membership");

    // the reference is the live set of the capture cycle, per bus
    capture_set_a: assert property (
        capture |=> st_reg.saved_valid && (st_reg.saved_a == $past(live_a)))
        else $error("membership not saved at capture point");

    capture_b_a: assert property (
        (capture && redundant) |=> st_reg.saved_b == $past(live_b))
        else $error("second bus membership not saved");

    // alarms follow the live comparison one cycle late
    missing_raise_a: assert property (
        (mon_en && |(saved_u & ~seen)) |=> missing_alarm_out)
        else $error("missing member alarm not raised");

    extra_raise_a: assert property (
        (mon_en && |(seen & ~saved_u)) |=> extra_alarm_out)
        else $error("extra member alarm not raised");

    // the two redundancy alarms exist only with both buses in use
    redundancy_raise_a: assert property (
        (mon_en && redundant && |((st_reg.saved_a & ~live_a & live_b) |
                                   (st_reg.saved_b & ~live_b & live_a)))
        |=> redundancy_lost_out)
        else $error("redundancy loss not flagged");

    improper_raise_a: assert property (
        (mon_en && redundant && |((live_a ^ live_b) & ~saved_u)) |=> improper_member_out)
        else $error("improper member not flagged");

    single_bus_a: assert property (
        !redundant |=> !redundancy_lost_out && !improper_member_out)
        else $error("redundancy alarm on a single bus");

    // a changed setting drops the reference at once
    cfg_clear_a: assert property (
        (avs_write_in && !avs_waitrequest_out && avs_address_in == msm_pkg::ADDR_CFG
         && cfg_changed && !capture) |=> !st_reg.saved_valid ##1 !missing_alarm_out)
        else $error("config change kept saved membership");

    // a held order must not start a second delay
    held_order_a: assert property (
        (st_reg.order && st_reg.order_prev && !(peer_snap_in && !st_reg.peer_prev)
         && st_reg.timer == '0) |=> !snap_active_out)
        else $error("held order restarted the delay");

    // one wait state, then a single answer cycle
    bus_answer_a: assert property (
        ((avs_read_in || avs_write_in) && avs_waitrequest_out)
        |=> !avs_waitrequest_out ##1 avs_waitrequest_out)
        else $error("bus answer not a single cycle");

endmodule // msm_monitor

// ### testbench/msm_peer_model.sv
// peer controllers on the shared bus: membership vectors and the peer snapshot flag
// assumes the bench sets the wanted membership; every change lands just after a rising edge
`timescale 1ns/1ps

module msm_peer_model (
    input  wire logic                  clk_in,
    input  wire logic                  arst_n_in,
    input  wire msm_pkg::msm_members_s want_in,
    input  wire logic [31:0]           drop_b_in,
    input  wire logic                  order_in,
    output msm_pkg::msm_members_s      bus_a_out,
    output msm_pkg::msm_members_s      bus_b_out,
    output logic                       peer_snap_out
);
    // ****************************************************************
    // peer behaviour
    // ****************************************************************
    logic [7:0] hold_reg;

    // bus b loses the units in the drop mask; a peer order holds the flag for its own delay
    always_ff @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            bus_a_out     <= '0;
            bus_b_out     <= '0;
            hold_reg      <= 8'h00;
            peer_snap_out <= 1'b0;
        end else begin
            bus_a_out     <= want_in;
            bus_b_out     <= want_in & ~{4{drop_b_in}};
            hold_reg      <= order_in ? 8'h28 : (hold_reg != 8'h00 ? hold_reg - 8'h01 : 8'h00);
            peer_snap_out <= order_in || (hold_reg > 8'h01);
        end
    end
endmodule // msm_peer_model

// ### testbench/member_snapshot_monitor_bench.sv
// member snapshot monitor bench: register traffic, own and peer snapshots, alarm checks
// assumes msm_monitor with a shortened delay and the peer model on its member inputs
`timescale 1ns/1ps

module member_snapshot_monitor_bench;
    // ****************************************************************
    // environment
    // ****************************************************************
    localparam int SNAP = 200;
    localparam int LEAD = 20;
    logic                  sys_clk = 1'b0;
    logic                  arst_n = 1'b0;
    logic [7:0]            address = 8'h00;
    logic                  rd = 1'b0;
    logic                  wr = 1'b0;
    logic [31:0]           wdata = 32'h0000_0000;
    logic [31:0]           rdata, r;
    logic                  waitreq, peer_snap, porder = 1'b0;
    msm_pkg::msm_members_s want = '0;
    msm_pkg::msm_members_s bus_a, bus_b;
    logic [31:0]           drop_b = 32'h0000_0000;
    logic                  flag, active, missing, extra, red_lost, improper;
    logic [3:0]            alarms;
    int                    seed = 32'h2d8d7fc6;
    int                    error_cnt = 0;
    int                    checked = 0;

    assign alarms = {missing, extra, red_lost, improper};
    always #12.5 sys_clk = ~sys_clk;

    msm_monitor #(.SNAP_CYCLES_P(SNAP), .LEAD_CYCLES_P(LEAD)) dut (
        .sys_clk_in(sys_clk), .arst_n_in(arst_n), .avs_address_in(address),
        .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
        .avs_byteenable_in(4'hF), .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
        .bus_a_in(bus_a), .bus_b_in(bus_b), .peer_snap_in(peer_snap),
        .snap_flag_out(flag), .snap_active_out(active), .missing_alarm_out(missing),
        .extra_alarm_out(extra), .redundancy_lost_out(red_lost),
        .improper_member_out(improper));

    msm_peer_model peers (
        .clk_in(sys_clk), .arst_n_in(arst_n), .want_in(want), .drop_b_in(drop_b),
        .order_in(porder), .bus_a_out(bus_a), .bus_b_out(bus_b), .peer_snap_out(peer_snap));

    task automatic close_out();
        $display("checks %0d, errors %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    // one avalon access; reads just after an edge see what that edge sampled
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int   n;
        logic done;
        n = 0;
        done = 1'b0;
        @(posedge sys_clk);
        address <= a;
        rd <= !w;
        wr <= w;
        wdata <= d;
        while (!done && n < 20) begin
            @(posedge sys_clk);
            done = !waitreq;
            n++;
        end
        r = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        if (!done) begin
            error_cnt++;
            close_out();
        end
    endtask

    task automatic settle(input msm_pkg::msm_members_s m, input logic [31:0] db);
        @(posedge sys_clk);
        want <= m;
        drop_b <= db;
        repeat (3) @(negedge sys_clk);
    endtask

    // start a delay, then watch it end; drop takes a saved genset away mid-delay
    task automatic snap(input logic by_peer, input logic drop);
        int n;
        int w;
        n = 0;
        w = 0;
        if (by_peer) begin
            @(posedge sys_clk);
            porder <= 1'b1;
            @(posedge sys_clk);
            porder <= 1'b0;
        end else begin
            bus(1'b1, msm_pkg::ADDR_CTRL, 32'h0000_0001);
        end
        do begin
            @(negedge sys_clk);
            w++;
        end while (!active && w < 10);
        if (!active) begin
            error_cnt++;
            close_out();
        end
        while (active && n < 300) begin
            check("peer flag", 32'(flag), 32'h1);
            check("muted alarms", 32'(alarms), 32'h0);
            n++;
            @(posedge sys_clk);
            if (drop && n == 50) want.genset[0] <= 1'b0;
            @(negedge sys_clk);
        end
        check("active cycles", n, SNAP);
    endtask

    function automatic logic [31:0] cnt_word(input logic [31:0] c, input logic [31:0] b);
        logic [5:0] pc;
        logic [5:0] pb;
        pc = 6'($countones(c));
        pb = 6'($countones(b));
        return {2'b00, pb, 2'b00, pc, 2'b00, pb, 2'b00, pc};
    endfunction

    initial begin
        msm_pkg::msm_members_s m;
        repeat (12) @(posedge sys_clk);
        arst_n <= 1'b1;
        bus(1'b0, msm_pkg::ADDR_STATUS, 32'h0);
        check("status after reset", r, 32'h0);
        bus(1'b0, 8'h20, 32'h0);
        check("unmapped read", r, 32'h0);
        m = {$random(seed), $random(seed), $random(seed), $random(seed)};
        m.genset[0] = 1'b1;
        m.group_controller[0] = 1'b1;
        m.breaker_control_unit_l1[31] = 1'b0;
        m.breaker_control_unit_l3[31] = 1'b0;
        settle(m, 32'h0);
        check("alarms unsaved", 32'(alarms), 32'h0);
        snap(1'b0, 1'b0);
        bus(1'b0, msm_pkg::ADDR_COUNT, 32'h0);
        check("counts l1", r, cnt_word(m.genset, m.breaker_control_unit_l1));
        bus(1'b0, msm_pkg::ADDR_SAVED_CTL, 32'h0);
        check("saved gensets", r, m.genset);
        bus(1'b0, msm_pkg::ADDR_SAVED_BCU, 32'h0);
        check("saved breakers", r, m.breaker_control_unit_l1);
        bus(1'b0, msm_pkg::ADDR_STATUS, 32'h0);
        check("status saved", r, 32'h2);
        check("held order", 32'(active), 32'h0);
        bus(1'b1, msm_pkg::ADDR_CTRL, 32'h0);
        m.genset[0] = 1'b0;
        settle(m, 32'h0);
        check("missing alarm", 32'(alarms), 32'h8);
        m.genset[0] = 1'b1;
        m.breaker_control_unit_l1[31] = 1'b1;
        settle(m, 32'h0);
        check("extra alarm", 32'(alarms), 32'h4);
        m.breaker_control_unit_l1[31] = 1'b0;
        settle(m, 32'h0);
        check("alarms clear", 32'(alarms), 32'h0);
        snap(1'b1, 1'b1);
        m.genset[0] = 1'b0;
        settle(m, 32'h0);
        check("alarms after peer", 32'(alarms), 32'h0);
        bus(1'b1, msm_pkg::ADDR_CFG, 32'h0000_0005);
        bus(1'b0, msm_pkg::ADDR_STATUS, 32'h0);
        check("cleared by id", r, 32'h0);
        bus(1'b1, msm_pkg::ADDR_CFG, 32'h0001_0405);
        snap(1'b0, 1'b0);
        bus(1'b0, msm_pkg::ADDR_COUNT, 32'h0);
        check("counts l3", r, cnt_word(m.group_controller, m.breaker_control_unit_l3));
        m.breaker_control_unit_l3[31] = 1'b1;
        settle(m, 32'h8000_0001);
        check("redundant", 32'({red_lost, improper, extra}), 32'h7);
        close_out();
    end
endmodule // member_snapshot_monitor_bench
